// *** pkg/coh_snoop_regs.vh ***
// Constants for the coherent interconnect snoop issue controller.
// Operation
// - Read ack is a one-cycle pulse, always taken in that cycle.
// - Read acknowledges carry no ID; the read tracker matches them in last-beat order.
// - Non-DVM snoop waits for earlier same-line transactions to be acknowledged.
// - Per ID, write responses return in write address issue order.
// - Exclusive-okay write response only for non-snooping writes.
// - Write ack is a one-cycle pulse, accepted in that same cycle.
// - Every write, barriers too, is acked, matched in write response order.
// - Read response bits 3:2 are zero for invalidates, barriers and DVM.
// - Non-snooping, write-back/clean/evict and evict are never snooped.
// - Unique writes and clean/make-unique become clean/make-invalid snoops.
// - Read-once and unique writes are widened to a full cache line.
// - Snoop valid and its address, protection and type held until ready.
// - Snoop addresses are aligned to the snoop data bus width in bytes.
// - Snoop type is four bits; only defined encodings are ever issued.
// - Snoop address width is a parameter; snoop protection is three bits.
`ifndef COH_SNOOP_REGS_VH
`define COH_SNOOP_REGS_VH

// ----------------------------------------------------------------------
// Snoop type encodings
// ----------------------------------------------------------------------
`define SNP_READ_ONCE 4'h0
`define SNP_READ_SHARED 4'h1
`define SNP_READ_CLEAN 4'h2
`define SNP_READ_NSD 4'h3
`define SNP_READ_UNIQUE 4'h7
`define SNP_CLEAN_SHARED 4'h8
`define SNP_CLEAN_INVALID 4'h9
`define SNP_MAKE_INVALID 4'hD
`define SNP_DVM_COMPLETE 4'hE
`define SNP_DVM_MESSAGE 4'hF

// ----------------------------------------------------------------------
// Originating transaction kinds on the user side
// ----------------------------------------------------------------------
`define SRC_READ_NO_SNOOP 5'h00
`define SRC_READ_ONCE 5'h01
`define SRC_READ_CLEAN 5'h02
`define SRC_READ_NSD 5'h03
`define SRC_READ_SHARED 5'h04
`define SRC_READ_UNIQUE 5'h05
`define SRC_CLEAN_UNIQUE 5'h06
`define SRC_MAKE_UNIQUE 5'h07
`define SRC_CLEAN_SHARED 5'h08
`define SRC_CLEAN_INVALID 5'h09
`define SRC_MAKE_INVALID 5'h0A
`define SRC_WRITE_NO_SNOOP 5'h0B
`define SRC_WRITE_UNIQUE 5'h0C
`define SRC_WRITE_LINE_UNIQUE 5'h0D
`define SRC_WRITE_BACK 5'h0E
`define SRC_WRITE_CLEAN 5'h0F
`define SRC_WRITE_EVICT 5'h10
`define SRC_EVICT 5'h11
`define SRC_BARRIER 5'h12
`define SRC_DVM_MESSAGE 5'h13
`define SRC_DVM_COMPLETE 5'h14

// ----------------------------------------------------------------------
// Response codes and reset values
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_EXOKAY 2'h1
`define AC_SNOOP_RST 4'h0
`define AC_PROT_RST 3'h0

`endif

// *** core/ack_order_queue.v ***
// In-order queue of outstanding acknowledge addresses with a match port.
`timescale 1ns/10ps
module ack_order_queue #(
    parameter DEPTH = 4,
    parameter PTR_W = 2,
    parameter W = 33
) (
    input wire ref_clk,
    input wire rst,
    input wire push,
    input wire [W-1:0] push_data,
    input wire pop,
    input wire [W-1:0] match_data,
    output wire full,
    output wire empty,
    output reg hit
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0] vld_ff;
    reg [PTR_W-1:0] wr_ff;
    reg [PTR_W-1:0] rd_ff;
    wire do_push;
    wire do_pop;
    integer i;

    assign full = &vld_ff;
    assign empty = ~|vld_ff;
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;

    // --------------------------------------------------------------
    // Storage and pointers
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            vld_ff <= {DEPTH{1'b0}};
            wr_ff <= {PTR_W{1'b0}};
            rd_ff <= {PTR_W{1'b0}};
        end else begin
            if (do_push) begin
                mem[wr_ff] <= push_data;
                vld_ff[wr_ff] <= 1'b1;
                wr_ff <= wr_ff + 1'b1;
            end
            // Acks pair with the oldest entry, as they carry no ID.
            if (do_pop) begin
                vld_ff[rd_ff] <= 1'b0;
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Address match over every live entry
    // --------------------------------------------------------------
    always @* begin
        hit = 1'b0;
        for (i = 0; i < DEPTH; i = i + 1) begin
            if (vld_ff[i] && mem[i] == match_data) begin
                hit = 1'b1;
            end
        end
    end
endmodule // ack_order_queue

// *** core/snoop_issue_ctrl.v ***
// Interconnect-side controller driving a cached master's snoop channel.
`timescale 1ns/10ps
`include "coh_snoop_regs.vh"
module snoop_issue_ctrl #(
    parameter AC_ADDR_W = 32,
    parameter LINE_SHIFT = 6,
    parameter DATA_SHIFT = 4,
    parameter TRK_DEPTH = 4,
    parameter TRK_PTR_W = 2
) (
    input wire ref_clk,
    input wire rst,
    input wire req_valid,
    input wire [4:0] req_kind,
    input wire [AC_ADDR_W-1:0] req_addr,
    input wire [2:0] req_prot,
    output wire req_ready,
    output wire acvalid,
    input wire acready,
    output wire [AC_ADDR_W-1:0] acaddr,
    output wire [3:0] acsnoop,
    output wire [2:0] acprot,
    input wire rvalid,
    input wire rready,
    input wire rlast,
    input wire [4:0] rd_kind,
    input wire [AC_ADDR_W-1:0] rd_addr,
    input wire [2:0] rd_prot,
    input wire rd_shared_in,
    input wire rd_dirty_in,
    output wire [1:0] rresp_hi,
    output wire rd_room,
    input wire rack,
    input wire bvalid,
    input wire bready,
    input wire [4:0] wr_kind,
    input wire [AC_ADDR_W-1:0] wr_addr,
    input wire [2:0] wr_prot,
    input wire [1:0] bresp_in,
    output wire [1:0] bresp,
    output wire wr_room,
    input wire wack
);
    localparam ST_IDLE = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_SEND = 2'h2;
    localparam KEY_W = AC_ADDR_W + 1;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg acvalid_ff;
    reg nxt_acvalid;
    reg [AC_ADDR_W-1:0] acaddr_ff;
    reg [AC_ADDR_W-1:0] nxt_acaddr;
    reg [3:0] acsnoop_ff;
    reg [3:0] nxt_acsnoop;
    reg [2:0] acprot_ff;
    reg [2:0] nxt_acprot;
    reg is_dvm_ff;
    reg nxt_is_dvm;
    reg drop;
    reg [3:0] snp_code;
    reg widen;
    wire rd_done;
    wire wr_done;
    wire rd_hit;
    wire wr_hit;
    wire rd_full;
    wire wr_full;
    wire [KEY_W-1:0] snp_key;

    // --------------------------------------------------------------
    // Address helpers
    // --------------------------------------------------------------
    function [AC_ADDR_W-1:0] align;
        input [AC_ADDR_W-1:0] a;
        input integer sh;
        begin
            align = (a >> sh) << sh;
        end
    endfunction

    // The secure bit acts as one more address bit in the hazard key.
    function [KEY_W-1:0] line_key;
        input prot1;
        input [AC_ADDR_W-1:0] a;
        begin
            line_key = {prot1, align(a, LINE_SHIFT)};
        end
    endfunction

    function no_share_bits;
        input [4:0] k;
        begin
            case (k)
                `SRC_CLEAN_INVALID: no_share_bits = 1'b1;
                `SRC_MAKE_INVALID: no_share_bits = 1'b1;
                `SRC_BARRIER: no_share_bits = 1'b1;
                `SRC_DVM_MESSAGE: no_share_bits = 1'b1;
                `SRC_DVM_COMPLETE: no_share_bits = 1'b1;
                default: no_share_bits = 1'b0;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // Response gating on the read and write response paths
    // --------------------------------------------------------------
    // These pass straight through so the response bits land in the
    // same beat as the data they qualify.
    assign rresp_hi = no_share_bits(rd_kind) ? 2'h0 :
        {rd_shared_in, rd_dirty_in};
    assign bresp = (bresp_in == `RESP_EXOKAY &&
        wr_kind != `SRC_WRITE_NO_SNOOP) ? `RESP_OKAY : bresp_in;

    // --------------------------------------------------------------
    // Acknowledge tracking
    // --------------------------------------------------------------
    assign rd_done = rvalid & rready & rlast;
    assign wr_done = bvalid & bready;
    assign rd_room = ~rd_full;
    assign wr_room = ~wr_full;
    assign snp_key = {acprot_ff[1], acaddr_ff};

    // Acks need no ready: they pop the queue in the cycle they arrive.
    ack_order_queue #(
        .DEPTH(TRK_DEPTH),
        .PTR_W(TRK_PTR_W),
        .W(KEY_W)
    ) u_rd_trk (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(rd_done),
        .push_data(line_key(rd_prot[1], rd_addr)),
        .pop(rack),
        .match_data(snp_key),
        .full(rd_full),
        .empty(),
        .hit(rd_hit)
    );

    // Write responses are forwarded in the order the user presents
    // them, which is issue order per ID on the write address path.
    ack_order_queue #(
        .DEPTH(TRK_DEPTH),
        .PTR_W(TRK_PTR_W),
        .W(KEY_W)
    ) u_wr_trk (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(wr_done),
        .push_data(line_key(wr_prot[1], wr_addr)),
        .pop(wack),
        .match_data(snp_key),
        .full(wr_full),
        .empty(),
        .hit(wr_hit)
    );

    // --------------------------------------------------------------
    // Filtering and conversion of originating transactions
    // --------------------------------------------------------------
    always @* begin
        drop = 1'b0;
        widen = 1'b1;
        snp_code = `SNP_READ_ONCE;
        case (req_kind)
            `SRC_READ_ONCE: snp_code = `SNP_READ_ONCE;
            `SRC_READ_CLEAN: snp_code = `SNP_READ_CLEAN;
            `SRC_READ_NSD: snp_code = `SNP_READ_NSD;
            `SRC_READ_SHARED: snp_code = `SNP_READ_SHARED;
            `SRC_READ_UNIQUE: snp_code = `SNP_READ_UNIQUE;
            `SRC_CLEAN_UNIQUE: snp_code = `SNP_CLEAN_INVALID;
            `SRC_MAKE_UNIQUE: snp_code = `SNP_MAKE_INVALID;
            `SRC_CLEAN_SHARED: snp_code = `SNP_CLEAN_SHARED;
            `SRC_CLEAN_INVALID: snp_code = `SNP_CLEAN_INVALID;
            `SRC_MAKE_INVALID: snp_code = `SNP_MAKE_INVALID;
            `SRC_WRITE_UNIQUE: snp_code = `SNP_CLEAN_INVALID;
            `SRC_WRITE_LINE_UNIQUE: snp_code = `SNP_MAKE_INVALID;
            `SRC_DVM_MESSAGE: begin
                snp_code = `SNP_DVM_MESSAGE;
                widen = 1'b0;
            end
            `SRC_DVM_COMPLETE: begin
                snp_code = `SNP_DVM_COMPLETE;
                widen = 1'b0;
            end
            // Anything else, unknown kinds too, is never snooped, so
            // no reserved type can reach the master.
            default: drop = 1'b1;
        endcase
    end

    // --------------------------------------------------------------
    // Snoop issue state machine
    // --------------------------------------------------------------
    assign req_ready = (state_ff == ST_IDLE);

    always @* begin
        nxt_state = state_ff;
        nxt_acvalid = acvalid_ff;
        nxt_acaddr = acaddr_ff;
        nxt_acsnoop = acsnoop_ff;
        nxt_acprot = acprot_ff;
        nxt_is_dvm = is_dvm_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid && !drop) begin
                    nxt_acsnoop = snp_code;
                    nxt_acprot = req_prot;
                    nxt_is_dvm = ~widen;
                    if (widen) begin
                        nxt_acaddr = align(req_addr, LINE_SHIFT);
                    end else begin
                        nxt_acaddr = align(req_addr, DATA_SHIFT);
                    end
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Conservative: any tracked entry on the same line and security space
                // holds back a non-DVM snoop, so a busy line can delay it for long.
                if (is_dvm_ff || !(rd_hit || wr_hit)) begin
                    nxt_acvalid = 1'b1;
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                // Fields stay frozen from HOLD until the master takes it.
                if (acready) begin
                    nxt_acvalid = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_acvalid = 1'b0;
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            acvalid_ff <= 1'b0;
            acaddr_ff <= {AC_ADDR_W{1'b0}};
            acsnoop_ff <= `AC_SNOOP_RST;
            acprot_ff <= `AC_PROT_RST;
            is_dvm_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            acvalid_ff <= nxt_acvalid;
            acaddr_ff <= nxt_acaddr;
            acsnoop_ff <= nxt_acsnoop;
            acprot_ff <= nxt_acprot;
            is_dvm_ff <= nxt_is_dvm;
        end
    end

    assign acvalid = acvalid_ff;
    assign acaddr = acaddr_ff;
    assign acsnoop = acsnoop_ff;
    assign acprot = acprot_ff;
endmodule // snoop_issue_ctrl

// *** bench/snoop_issue_ctrl_sva.sv ***
// Concurrent checks on the snoop issue controller ports.
`timescale 1ns/10ps
`include "coh_snoop_regs.vh"
module snoop_issue_ctrl_sva #(
    parameter AC_ADDR_W = 32,
    parameter DATA_SHIFT = 4
) (
    input wire ref_clk,
    input wire rst,
    input wire req_valid,
    input wire [4:0] req_kind,
    input wire req_ready,
    input wire acvalid,
    input wire acready,
    input wire [AC_ADDR_W-1:0] acaddr,
    input wire [3:0] acsnoop,
    input wire [2:0] acprot,
    input wire [4:0] rd_kind,
    input wire rd_shared_in,
    input wire rd_dirty_in,
    input wire [1:0] rresp_hi,
    input wire [4:0] wr_kind,
    input wire [1:0] bresp_in,
    input wire [1:0] bresp
);
// ----------
// Checks
// ----------
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
wire take = req_valid && req_ready;
wire drop_k = req_kind == `SRC_READ_NO_SNOOP || req_kind > `SRC_DVM_COMPLETE ||
    (req_kind >= `SRC_WRITE_BACK && req_kind <= `SRC_BARRIER) ||
    req_kind == `SRC_WRITE_NO_SNOOP;
wire rd_void = rd_kind == `SRC_CLEAN_INVALID ||
    (rd_kind >= `SRC_BARRIER && rd_kind <= `SRC_DVM_COMPLETE) ||
    rd_kind == `SRC_MAKE_INVALID;
a_ac_hold_stable: assert property (acvalid && !acready |=> acvalid &&
    $stable(acaddr) && $stable(acsnoop) && $stable(acprot))
    else $error("snoop fields moved before ready");
a_ac_release_low: assert property (acvalid && acready |=> !acvalid)
    else $error("snoop valid stayed after handshake");
a_ac_addr_align: assert property (acvalid |->
    (acaddr & ((1 << DATA_SHIFT) - 1)) == 0)
    else $error("snoop address misaligned");
a_snoop_code_legal: assert property (acvalid |-> acsnoop inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hD, 4'hE, 4'hF})
    else $error("reserved snoop type issued");
a_rresp_bits_clear: assert property (rd_void |-> rresp_hi == 2'h0)
    else $error("shared or dirty bit set");
a_rresp_bits_pass: assert property (!rd_void |->
    rresp_hi == {rd_shared_in, rd_dirty_in})
    else $error("read response bits altered");
a_exokay_kind_gate: assert property (bresp == `RESP_EXOKAY |->
    wr_kind == `SRC_WRITE_NO_SNOOP)
    else $error("exclusive okay on snooping write");
a_bresp_plain_pass: assert property (bresp_in != `RESP_EXOKAY |->
    bresp == bresp_in)
    else $error("write response altered");
a_drop_no_snoop: assert property (take && drop_k |=>
    req_ready && !acvalid)
    else $error("filtered kind reached snoop port");
a_busy_after_take: assert property (take && !drop_k |=>
    !req_ready [*2])
    else $error("request taken while snoop in flight");
c_stalled_snoop: cover property (acvalid && !acready ##1 acready);
c_rresp_forced: cover property (rd_void && rd_shared_in);
c_dropped_kind: cover property (take && drop_k);
endmodule // snoop_issue_ctrl_sva
bind snoop_issue_ctrl snoop_issue_ctrl_sva #(.AC_ADDR_W(AC_ADDR_W),
    .DATA_SHIFT(DATA_SHIFT)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready),
    .acvalid(acvalid), .acready(acready), .acaddr(acaddr),
    .acsnoop(acsnoop), .acprot(acprot), .rd_kind(rd_kind),
    .rd_shared_in(rd_shared_in), .rd_dirty_in(rd_dirty_in),
    .rresp_hi(rresp_hi), .wr_kind(wr_kind), .bresp_in(bresp_in),
    .bresp(bresp));

// *** bench/cached_master_model.sv ***
// Behavioural cached master on the far side of the snoop channel.
`timescale 1ns/10ps
module cached_master_model (
    input wire ref_clk,
    input wire rst,
    input wire [4:0] ack_lag,
    input wire rd_done,
    input wire wr_done,
    input wire acvalid,
    input wire [31:0] acaddr,
    input wire [3:0] acsnoop,
    input wire [2:0] acprot,
    output reg acready,
    output reg rack,
    output reg wack,
    output reg seen,
    output reg [31:0] seen_addr,
    output reg [3:0] seen_snoop,
    output reg [2:0] seen_prot
);
// ----------
// Behaviour
// ----------
integer seed = 32'h45ceac4c;
reg [5:0] rcnt_ff = 6'h00;
reg [5:0] wcnt_ff = 6'h00;
reg [31:0] r;
// One pending ack per side is enough: completions only overlap in the
// last bench scenario, which ends the run before any ack falls due.
always @(posedge ref_clk) begin
    r = $random(seed);
    acready <= r[0] | r[1];
    seen <= acvalid && acready;
    if (acvalid && acready) begin
        seen_addr <= acaddr;
        seen_snoop <= acsnoop;
        seen_prot <= acprot;
    end
    rack <= !rst && rcnt_ff == 6'h01;
    wack <= !rst && wcnt_ff == 6'h01;
    if (rst) rcnt_ff <= 6'h00;
    else if (rd_done) rcnt_ff <= {1'b0, ack_lag} + 6'h02;
    else if (rcnt_ff != 6'h00) rcnt_ff <= rcnt_ff - 6'h01;
    if (rst) wcnt_ff <= 6'h00;
    else if (wr_done) wcnt_ff <= {1'b0, ack_lag} + 6'h02;
    else if (wcnt_ff != 6'h00) wcnt_ff <= wcnt_ff - 6'h01;
end
endmodule // cached_master_model

// *** bench/snoop_issue_ctrl_bench.sv ***
// Self-checking bench for the snoop issue controller.
`timescale 1ns/10ps
`include "coh_snoop_regs.vh"
module snoop_issue_ctrl_bench;
reg ref_clk = 0, rst = 1, req_valid = 0, rv = 0, bv = 0, shr = 0, drt = 0;
reg [4:0] req_kind = 0, rd_kind = 0, wr_kind = 0, ack_lag = 0;
reg [31:0] req_addr = 0, rd_addr = 0, wr_addr = 0, a;
reg [2:0] req_prot = 0, rd_prot = 0, wr_prot = 0;
reg [1:0] bresp_in = 0;
reg [4:0] e;
wire req_ready, acvalid, acready, rack, wack, seen, rd_room, wr_room;
wire [31:0] acaddr, seen_addr;
wire [3:0] acsnoop, seen_snoop;
wire [2:0] acprot, seen_prot;
wire [1:0] rresp_hi, bresp;
integer seed = 32'h45ceac4c, mismatches = 0, n_checks = 0, cyc = 0;
integer i, j, n;
snoop_issue_ctrl dut_u (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
    .req_prot(req_prot), .req_ready(req_ready), .acvalid(acvalid),
    .acready(acready), .acaddr(acaddr), .acsnoop(acsnoop),
    .acprot(acprot), .rvalid(rv), .rready(rv), .rlast(rv),
    .rd_kind(rd_kind), .rd_addr(rd_addr), .rd_prot(rd_prot),
    .rd_shared_in(shr), .rd_dirty_in(drt), .rresp_hi(rresp_hi),
    .rd_room(rd_room), .rack(rack), .bvalid(bv), .bready(bv),
    .wr_kind(wr_kind),
    .wr_addr(wr_addr), .wr_prot(wr_prot), .bresp_in(bresp_in),
    .bresp(bresp), .wr_room(wr_room), .wack(wack));
cached_master_model far_u (.ref_clk(ref_clk), .rst(rst),
    .ack_lag(ack_lag), .rd_done(rv), .wr_done(bv), .acvalid(acvalid),
    .acaddr(acaddr), .acsnoop(acsnoop), .acprot(acprot),
    .acready(acready), .rack(rack), .wack(wack), .seen(seen),
    .seen_addr(seen_addr), .seen_snoop(seen_snoop),
    .seen_prot(seen_prot));
// ----------
// Helpers
// ----------
initial forever #4 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
        mismatches = mismatches + 1;
        close_out;
    end
end
task close_out;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end
endtask
task check_val(input [95:0] nm, input [31:0] ex, input [31:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== ex) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s exp %h got %h", nm, ex, got);
        end
    end
endtask
function [4:0] conv(input [4:0] k);
    case (k)
        `SRC_READ_ONCE: conv = {1'b1, `SNP_READ_ONCE};
        `SRC_READ_SHARED: conv = {1'b1, `SNP_READ_SHARED};
        `SRC_READ_CLEAN: conv = {1'b1, `SNP_READ_CLEAN};
        `SRC_READ_NSD: conv = {1'b1, `SNP_READ_NSD};
        `SRC_READ_UNIQUE: conv = {1'b1, `SNP_READ_UNIQUE};
        `SRC_CLEAN_SHARED: conv = {1'b1, `SNP_CLEAN_SHARED};
        `SRC_CLEAN_INVALID, `SRC_CLEAN_UNIQUE, `SRC_WRITE_UNIQUE:
            conv = {1'b1, `SNP_CLEAN_INVALID};
        `SRC_MAKE_INVALID, `SRC_MAKE_UNIQUE, `SRC_WRITE_LINE_UNIQUE:
            conv = {1'b1, `SNP_MAKE_INVALID};
        `SRC_DVM_COMPLETE: conv = {1'b1, `SNP_DVM_COMPLETE};
        `SRC_DVM_MESSAGE: conv = {1'b1, `SNP_DVM_MESSAGE};
        default: conv = 5'h00;
    endcase
endfunction
task send(input [4:0] k, input [31:0] ad, input [2:0] p);
    begin
        @(negedge ref_clk);
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            n = n + 1;
            @(negedge ref_clk);
        end
        if (n == 200) begin
            mismatches = mismatches + 1;
            close_out;
        end
        req_valid = 1;
        req_kind = k;
        req_addr = ad;
        req_prot = p;
        @(negedge ref_clk);
        req_valid = 0;
    end
endtask
task wait_seen;
    begin
        n = 0;
        while (seen !== 1'b1 && n < 100) begin
            n = n + 1;
            @(negedge ref_clk);
        end
    end
endtask
// ----------
// Scenarios
// ----------
initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst = 0;
    // Every kind, plus two unknown codes, with random payloads.
    for (j = 0; j < 3; j = j + 1) for (i = 0; i < 23; i = i + 1) begin
        a = $random(seed);
        e = conv(i);
        shr = a[0];
        drt = a[1];
        bresp_in = a[3:2];
        rd_kind = i;
        wr_kind = i;
        #1;
        check_val("rresp_hi", (i == 9 || i == 10 || i >= 18 && i <= 20) ?
            0 : {shr, drt}, rresp_hi);
        check_val("bresp", (a[3:2] == 1 && i != 11) ? 0 : a[3:2],
            bresp);
        send(i, a, a[6:4]);
        wait_seen;
        check_val("issued", e[4], seen);
        if (e[4]) begin
            check_val("type", e[3:0], seen_snoop);
            check_val("prot", a[6:4], seen_prot);
            check_val("addr", (i >= 19) ? a & ~32'hF : a & ~32'h3F,
                seen_addr);
        end
    end
    // Same line snoop waits for the ack; other security space does not.
    ack_lag = 20;
    for (i = 0; i < 4; i = i + 1) begin
        a = $random(seed) & ~32'h3F;
        @(negedge ref_clk);
        rd_addr = a;
        wr_addr = a;
        rd_prot = 3'h2;
        wr_prot = 3'h2;
        rd_kind = `SRC_READ_SHARED;
        wr_kind = `SRC_WRITE_BACK;
        rv = !i[0];
        bv = i[0];
        @(negedge ref_clk);
        rv = 0;
        bv = 0;
        send(`SRC_READ_SHARED, a + 32'h8, {1'b0, i[1], 1'b0});
        wait_seen;
        check_val("held", i[1], n >= 16);
        repeat (30) @(negedge ref_clk);
    end
    // Back-to-back completions fill both trackers and withdraw room.
    check_val("room", 2'h3, {rd_room, wr_room});
    @(negedge ref_clk);
    rv = 1;
    bv = 1;
    repeat (4) @(negedge ref_clk);
    rv = 0;
    bv = 0;
    check_val("full", 2'h0, {rd_room, wr_room});
    close_out;
end
endmodule // snoop_issue_ctrl_bench
